/* File: design/pcg_clock_gate_map.vh */
`ifndef PCG_CLOCK_GATE_MAP_VH
`define PCG_CLOCK_GATE_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------
`define PCG_IDX_TIMER       12'hf74
`define PCG_IDX_SERIAL      12'hf75
`define PCG_IDX_CALENDAR    12'hf76
`define PCG_IDX_EXTIRQ      12'hf77
`define PCG_IDX_RUN_BASE    12'hf78
`define PCG_REG_COUNT       4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCG_RST_GATE        8'h00
`define PCG_RST_RDATA       32'h00000000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCG_BIT_TIMER_PAIR_B   5
`define PCG_BIT_TIMER_PAIR_A   4
`define PCG_BIT_WIDE_TIMER1    1
`define PCG_BIT_WIDE_TIMER0    0
`define PCG_BIT_I2C_PORT       4
`define PCG_BIT_ASYNC_SERIAL1  1
`define PCG_BIT_ASYNC_SERIAL0  0
`define PCG_BIT_CALENDAR       4
`define PCG_BIT_SYNC_SERIAL0   0
`define PCG_BIT_EXT_IRQ_TOP    5
`define PCG_BIT_EXT_IRQ_LOW    0

// ----------------------------------------------------------------------
// Gate slot count (15 peripherals plus spare slot 6)
// ----------------------------------------------------------------------
`define PCG_NUM_PERIPH      16

`endif

/* File: design/pcg_base_clock.v */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Basic clock phase: half the system clock rate, shared by all gates
// ----------------------------------------------------------------------
module pcg_base_clock (
  input  wire clock,
  input  wire reset,
  output wire phaseNxt,
  output wire phase
);

  reg phase_r;

  // Common phase keeps all peripheral clocks aligned to each other
  assign phaseNxt = ~phase_r;
  assign phase    = phase_r;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= phaseNxt;
    end
  end

endmodule // pcg_base_clock

/* File: design/pcg_gate_cell.v */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Glitch-free gate for one peripheral basic clock
// ----------------------------------------------------------------------
module pcg_gate_cell (
  input  wire clock,
  input  wire reset,
  input  wire enable,
  input  wire phaseNxt,
  output wire gatedClk,
  output wire running
);

  reg  armed_r;
  reg  gatedClk_r;
  wire armed_nxt;
  wire gatedClk_nxt;

  // Enable is only taken while the next phase is low, so a high pulse
  // is never cut short or started half way
  assign armed_nxt    = phaseNxt ? armed_r : enable;
  assign gatedClk_nxt = phaseNxt & armed_nxt;
  assign gatedClk     = gatedClk_r;
  assign running      = armed_r;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      armed_r    <= 1'b0;
      gatedClk_r <= 1'b0;
    end else begin
      armed_r    <= armed_nxt;
      gatedClk_r <= gatedClk_nxt;
    end
  end

endmodule // pcg_gate_cell

/* File: design/pcg_peripheral_clock_gating.v */
`timescale 1ns/1ps
`include "pcg_clock_gate_map.vh"

module pcg_peripheral_clock_gating (
  input  wire        clock,
  input  wire        reset,
  input  wire [11:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output wire [31:0] readdata,
  output wire        waitrequest,
  output wire        timerPairBClk,
  output wire        timerPairAClk,
  output wire        wideTimer1Clk,
  output wire        wideTimer0Clk,
  output wire        i2cPortClk,
  output wire        asyncSerial1Clk,
  output wire        asyncSerial0Clk,
  output wire        calendarClk,
  output wire        syncSerial0Clk,
  output wire        extIrq5Clk,
  output wire        extIrq4Clk,
  output wire        extIrq3Clk,
  output wire        extIrq2Clk,
  output wire        extIrq1Clk,
  output wire        extIrq0Clk
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg  [7:0]  gateReg_r [0:`PCG_REG_COUNT-1];
  reg  [31:0] readdata_r;
  reg  [31:0] readdata_nxt;
  reg         waitReq_r;
  wire        request;
  wire        commit;
  wire [11:0] gateOff;
  wire [11:0] runOff;
  wire        gateHit;
  wire        runHit;
  wire [1:0]  gateIdx;
  wire [1:0]  runIdx;
  wire [15:0] enVec;
  wire [15:0] clkVec;
  wire [15:0] runVec;
  wire [7:0]  runReg [0:`PCG_REG_COUNT-1];
  wire        phaseNxt;
  integer     i;

  // --------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the transfer completes
  // --------------------------------------------------------------------
  assign request     = read | write;
  assign commit      = request & ~waitReq_r;
  assign waitrequest = waitReq_r;
  assign readdata    = readdata_r;

  assign gateOff = address - `PCG_IDX_TIMER;
  assign runOff  = address - `PCG_IDX_RUN_BASE;
  assign gateHit = (address >= `PCG_IDX_TIMER) && (address <= `PCG_IDX_EXTIRQ);
  assign runHit  = (address >= `PCG_IDX_RUN_BASE) &&
                   (runOff < `PCG_REG_COUNT);
  assign gateIdx = gateOff[1:0];
  assign runIdx  = runOff[1:0];

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      waitReq_r <= 1'b1;
    end else if (request && waitReq_r) begin
      waitReq_r <= 1'b0;
    end else begin
      waitReq_r <= 1'b1;
    end
  end

  // Read data is captured in the wait cycle and held through completion;
  // unmapped addresses read as zero and ignore writes
  always @* begin
    readdata_nxt = `PCG_RST_RDATA;
    if (gateHit) begin
      readdata_nxt[7:0] = gateReg_r[gateIdx];
    end else if (runHit) begin
      readdata_nxt[7:0] = runReg[runIdx];
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      readdata_r <= `PCG_RST_RDATA;
    end else if (read && waitReq_r) begin
      readdata_r <= readdata_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Gating registers, all bits read/write
  // --------------------------------------------------------------------
  // Write lands on the completion edge, so the gate cannot move before
  // the master sees the transfer finish
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      for (i = 0; i < `PCG_REG_COUNT; i = i + 1) begin
        gateReg_r[i] <= `PCG_RST_GATE;
      end
    end else if (commit && write && gateHit && byteenable[0]) begin
      gateReg_r[gateIdx] <= writedata[7:0];
    end
  end

  // --------------------------------------------------------------------
  // Enable vector: one bit per gated peripheral
  // --------------------------------------------------------------------
  assign enVec[15] = gateReg_r[0][`PCG_BIT_TIMER_PAIR_B];
  assign enVec[14] = gateReg_r[0][`PCG_BIT_TIMER_PAIR_A];
  assign enVec[13] = gateReg_r[0][`PCG_BIT_WIDE_TIMER1];
  assign enVec[12] = gateReg_r[0][`PCG_BIT_WIDE_TIMER0];
  assign enVec[11] = gateReg_r[1][`PCG_BIT_I2C_PORT];
  assign enVec[10] = gateReg_r[1][`PCG_BIT_ASYNC_SERIAL1];
  assign enVec[9]  = gateReg_r[1][`PCG_BIT_ASYNC_SERIAL0];
  assign enVec[8]  = gateReg_r[2][`PCG_BIT_CALENDAR];
  assign enVec[7]  = gateReg_r[2][`PCG_BIT_SYNC_SERIAL0];
  assign enVec[6]  = 1'b0;
  assign enVec[5:0] = gateReg_r[3][`PCG_BIT_EXT_IRQ_TOP:`PCG_BIT_EXT_IRQ_LOW];

  // --------------------------------------------------------------------
  // Running state readback, same bit layout as the gating registers
  // --------------------------------------------------------------------
  assign runReg[0] = {2'b00, runVec[15], runVec[14], 2'b00, runVec[13], runVec[12]};
  assign runReg[1] = {3'b000, runVec[11], 2'b00, runVec[10], runVec[9]};
  assign runReg[2] = {3'b000, runVec[8], 3'b000, runVec[7]};
  assign runReg[3] = {2'b00, runVec[5:0]};

  // --------------------------------------------------------------------
  // Basic clock and per-peripheral gates
  // --------------------------------------------------------------------
  pcg_base_clock u_base (
    .clock    (clock),
    .reset    (reset),
    .phaseNxt (phaseNxt),
    .phase    ()
  );

  // Slot 6 is a spare with its enable tied off; it keeps the loop uniform
  genvar g;
  generate
    for (g = 0; g < `PCG_NUM_PERIPH; g = g + 1) begin : gate
      pcg_gate_cell u_cell (
        .clock    (clock),
        .reset    (reset),
        .enable   (enVec[g]),
        .phaseNxt (phaseNxt),
        .gatedClk (clkVec[g]),
        .running  (runVec[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Named peripheral clocks
  // --------------------------------------------------------------------
  assign timerPairBClk   = clkVec[15];
  assign timerPairAClk   = clkVec[14];
  assign wideTimer1Clk   = clkVec[13];
  assign wideTimer0Clk   = clkVec[12];
  assign i2cPortClk      = clkVec[11];
  assign asyncSerial1Clk = clkVec[10];
  assign asyncSerial0Clk = clkVec[9];
  assign calendarClk     = clkVec[8];
  assign syncSerial0Clk  = clkVec[7];
  assign extIrq5Clk      = clkVec[5];
  assign extIrq4Clk      = clkVec[4];
  assign extIrq3Clk      = clkVec[3];
  assign extIrq2Clk      = clkVec[2];
  assign extIrq1Clk      = clkVec[1];
  assign extIrq0Clk      = clkVec[0];

endmodule // pcg_peripheral_clock_gating

/* File: tb/pcg_props.sv */
`timescale 1ns/1ps
`include "pcg_clock_gate_map.vh"

module pcg_props (
  input logic        clock,
  input logic        reset,
  input logic [11:0] address,
  input logic        write,
  input logic [31:0] writedata,
  input logic [3:0]  byteenable,
  input logic        waitrequest,
  input logic        timerPairBClk,
  input logic        wideTimer0Clk,
  input logic        i2cPortClk,
  input logic        calendarClk,
  input logic        extIrq0Clk,
  input logic        extIrq3Clk,
  input logic        extIrq5Clk
);
  // ------
  // Gate checks
  // ------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // A write counts only at its completion edge
  wire wr = write && !waitrequest && byteenable[0];
  wire anyClk = timerPairBClk | wideTimer0Clk | i2cPortClk | calendarClk | extIrq0Clk;
  property p_rst_quiet; $fell(reset) |-> !anyClk; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("clock after reset");
  property p_one_high; $rose(i2cPortClk) |=> $fell(i2cPortClk); endproperty
  a_one_high: assert property (p_one_high) else $error("long high pulse");
  property p_in_phase; extIrq0Clk |-> !$past(extIrq5Clk); endproperty
  a_in_phase: assert property (p_in_phase) else $error("clocks out of phase");
  property p_tmr_on;
    wr && address == `PCG_IDX_TIMER && writedata[5] |-> ##[1:4] timerPairBClk; endproperty
  a_tmr_on: assert property (p_tmr_on) else $error("timer clock absent");
  property p_ser_on;
    wr && address == `PCG_IDX_SERIAL && writedata[4] |-> ##[1:4] i2cPortClk; endproperty
  a_ser_on: assert property (p_ser_on) else $error("i2c clock absent");
  property p_cal_on;
    wr && address == `PCG_IDX_CALENDAR && writedata[4] |-> ##[1:4] calendarClk; endproperty
  a_cal_on: assert property (p_cal_on) else $error("calendar clock absent");
  property p_irq_on;
    wr && address == `PCG_IDX_EXTIRQ && writedata[3] |-> ##[1:4] extIrq3Clk; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq clock absent");
  property p_tmr_off;
    wr && address == `PCG_IDX_TIMER && !writedata[0] |-> ##3 !wideTimer0Clk [*4]; endproperty
  a_tmr_off: assert property (p_tmr_off) else $error("clock not stopped");
endmodule // pcg_props

bind pcg_peripheral_clock_gating pcg_props u_props (.clock(clock), .reset(reset),
  .address(address), .write(write), .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest), .timerPairBClk(timerPairBClk), .wideTimer0Clk(wideTimer0Clk),
  .i2cPortClk(i2cPortClk), .calendarClk(calendarClk), .extIrq0Clk(extIrq0Clk),
  .extIrq3Clk(extIrq3Clk), .extIrq5Clk(extIrq5Clk));

/* File: tb/pcg_periph_model.sv */
`timescale 1ns/1ps

// ------
// Gated peripherals: count basic clock pulses
// ------
module pcg_periph_model (
  input  logic        clock,
  input  logic        reset,
  input  logic        clr,
  input  logic [14:0] gatedClk,
  output int          cnt [15]
);
  logic [14:0] prev;
  // Sampled on system clock edges; a half-rate clock loses no pulse this way
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      prev <= '0;
      cnt <= '{default: 0};
    end else begin
      prev <= gatedClk;
      for (int i = 0; i < 15; i++) cnt[i] <= clr ? 0 : cnt[i] + int'(gatedClk[i] & ~prev[i]);
    end
  end
endmodule // pcg_periph_model

/* File: tb/tb.sv */
`timescale 1ns/1ps

module tb;
  logic        clock = 0;
  logic        reset = 1;
  logic        read = 0;
  logic        write = 0;
  logic        clr = 0;
  logic [11:0] address = '0;
  logic [31:0] writedata = '0;
  logic [3:0]  byteenable = '0;
  logic [31:0] q;
  logic [7:0]  gate [4];
  wire  [31:0] readdata;
  wire         waitrequest;
  wire  [14:0] clks;
  int          cnt [15];
  int          fails = 0;
  int          cmp_count = 0;
  int          seed = 32;
  // Register index and bit of each gated clock, in clks order
  logic [7:0]  posMap [15] = '{8'h05, 8'h04, 8'h01, 8'h00, 8'h14, 8'h11, 8'h10, 8'h24,
                               8'h20, 8'h35, 8'h34, 8'h33, 8'h32, 8'h31, 8'h30};
  // ------
  // Setup and checks
  // ------
  initial forever #20 clock = ~clock;
  pcg_peripheral_clock_gating DUT (.clock(clock), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .timerPairBClk(clks[0]),
    .timerPairAClk(clks[1]), .wideTimer1Clk(clks[2]), .wideTimer0Clk(clks[3]),
    .i2cPortClk(clks[4]), .asyncSerial1Clk(clks[5]), .asyncSerial0Clk(clks[6]),
    .calendarClk(clks[7]), .syncSerial0Clk(clks[8]), .extIrq5Clk(clks[9]),
    .extIrq4Clk(clks[10]), .extIrq3Clk(clks[11]), .extIrq2Clk(clks[12]),
    .extIrq1Clk(clks[13]), .extIrq0Clk(clks[14]));
  pcg_periph_model u_model (.clock(clock), .reset(reset), .clr(clr), .gatedClk(clks),
    .cnt(cnt));
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: register %h expected %h", $time, got, exp);
    end
  endtask
  task chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: pulses %0d expected %0d", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; only the watchdog ends a hang
  task bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= !wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // Running readback shows only the named enables, once each gate has settled
  logic [7:0]  runMask [4] = '{8'h33, 8'h13, 8'h11, 8'h3f};
  task check_regs;
    for (int r = 0; r < 4; r++) begin
      bus(1'b0, 12'hf74 + 12'(r), 8'h00, 4'h0);
      chk_reg(q, {24'h0, gate[r]});
    end
    for (int r = 0; r < 4; r++) begin
      bus(1'b0, 12'hf78 + 12'(r), 8'h00, 4'h0);
      chk_reg(q, {24'h0, gate[r] & runMask[r]});
    end
  endtask
  // Twenty sampled edges hold exactly ten pulses of a running half-rate clock
  task measure;
    repeat (4) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (20) @(posedge clock);
    #1;
    for (int i = 0; i < 15; i++)
      chk_cnt(cnt[i], gate[posMap[i][7:4]][posMap[i][3:0]] ? 10 : 0);
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] d;
    logic [3:0] be;
    for (int r = 0; r < 4; r++) gate[r] = 8'h00;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    check_regs;
    bus(1'b0, 12'h100, 8'h00, 4'h0);
    chk_reg(q, 32'h0);
    bus(1'b1, 12'h100, 8'hff, 4'hf);
    bus(1'b1, 12'hf78, 8'hff, 4'hf);
    check_regs;
    measure;
    for (int i = 0; i < 16; i++) begin
      d = i < 4 ? 8'hff : i < 8 ? 8'h00 : 8'($random(seed));
      be = i < 8 ? 4'hf : 4'($random(seed));
      bus(1'b1, 12'hf74 + 12'(i % 4), d, be);
      if (be[0]) gate[i % 4] = d;
      check_regs;
      measure;
    end
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    for (int r = 0; r < 4; r++) gate[r] = 8'h00;
    check_regs;
    measure;
    tally_and_finish;
  end
endmodule // tb
